// >>> common/adcirq_regs.vh
// Register map, field positions and reset values of the converter
// interrupt and result register bank.
// Assumes byte addresses on a 32-bit register port.
`ifndef ADCIRQ_REGS_VH
`define ADCIRQ_REGS_VH

// ==========================================================
// Offsets
`define ADCIRQ_ADDR_W 8
`define ADCIRQ_OFF_FLAGS 8'h18
`define ADCIRQ_OFF_FLAG_CLEAR 8'h1c
`define ADCIRQ_OFF_ENABLE_SET 8'h20
`define ADCIRQ_OFF_ENABLE_CLEAR 8'h24
`define ADCIRQ_OFF_MASK_VIEW 8'h28
`define ADCIRQ_OFF_LAST_RESULT 8'h2c
`define ADCIRQ_OFF_CHAN_PRESENCE 8'h30

// ==========================================================
// Flag bit positions
`define ADCIRQ_BIT_COMPARE_ELSE 14
`define ADCIRQ_BIT_GREATER_THAN 13
`define ADCIRQ_BIT_LESS_THAN 12
`define ADCIRQ_BIT_BUSY 9
`define ADCIRQ_BIT_READY 8
`define ADCIRQ_BIT_CONTACT_LOST 5
`define ADCIRQ_BIT_PEN_CONTACT 4
`define ADCIRQ_BIT_OVERRUN 1
`define ADCIRQ_BIT_RESULT_READY 0
`define ADCIRQ_FLAG_MASK 32'h0000_7333
`define ADCIRQ_EDGE_MASK 32'h0000_7332

// ==========================================================
// Result fields and reset values
`define ADCIRQ_VALUE_W 12
`define ADCIRQ_CHAN_W 8
`define ADCIRQ_CHAN_LSB 16
`define ADCIRQ_RST_FLAGS 32'h0000_0000
`define ADCIRQ_RST_MASK 32'h0000_0000
`define ADCIRQ_RST_RESULT 32'h0000_0000
`define ADCIRQ_CHAN_PRESENCE_DEF 32'h0000_03ff

`endif

// >>> logic/adcirq_sync2.v
// Two-flop synchroniser for a bus of levels.
// Assumes inputs come from outside the clk_i domain.
`timescale 1ns/10ps
`default_nettype none

module adcirq_sync2 #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_b_i,
    // Data
    input wire [WIDTH-1:0] d_i,
    output reg [WIDTH-1:0] q_o
);

    reg [WIDTH-1:0] meta_reg;

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_reg <= {WIDTH{1'b0}};
            q_o <= {WIDTH{1'b0}};
        end else begin
            meta_reg <= d_i;
            q_o <= meta_reg;
        end
    end

endmodule

`default_nettype wire

// >>> logic/adcirq_bank.v
// Interrupt flags, interrupt mask, last result and channel presence
// registers of the converter interface.
// Assumes live status levels and the result toggle come from the converter
// core, possibly from another clock, and are synchronised here.
//
// Notes on behaviour
// R1 - Flag bits: 14,13,12 compare; 9 busy; 8 ready; 5,4 contact; 1 overrun; 0 data.
// R2 - Non-data flags set on rising edge of live status, sticky until cleared.
// R3 - Data-ready flag sets when a new result is stored.
// R4 - Flags clear only by writing one to the clear port; flags read-only.
// R5 - Clear write drops both the flag and the request it drives.
// R6 - Zero bits written to clear, enable, disable ports change nothing.
// R7 - Writing one to enable port sets matching mask bit.
// R8 - Writing one to disable port clears matching mask bit.
// R9 - Mask view reads enabled sources as one, same layout as flags.
// R10 - Each conversion end loads 12-bit result into bits 11:0, held.
// R11 - Converted channel number stored in bits 23:16 with the result.
// R12 - Presence register returns one per implemented channel, 32 bits.
// R13 - Greater-than status reflects result above high value while compare on.
// R14 - Overrun status set after any overrun since sequence start.
// R15 - Interrupt output high while any flag and its mask bit are set.
//
// Our own choice: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "adcirq_regs.vh"

module adcirq_bank #(
    parameter [31:0] CHAN_PRESENCE = `ADCIRQ_CHAN_PRESENCE_DEF
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_b_i,
    // Register port
    input wire [`ADCIRQ_ADDR_W-1:0] addr_i,
    input wire [31:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [31:0] rdata_o,
    // Live status levels from converter core, bit layout of the flags
    input wire [31:0] live_status_i,
    // Conversion result, toggles once per finished conversion
    input wire result_toggle_i,
    input wire [`ADCIRQ_VALUE_W-1:0] result_value_i,
    input wire [`ADCIRQ_CHAN_W-1:0] result_channel_i,
    // Interrupt request
    output reg irq_o
);

    // ==========================================================
    // Synchronisers
    // The result bus is held stable by the core for many cycles after
    // the toggle, so it is sampled only once the toggle has crossed.
    wire [31:0] status_sync;
    wire toggle_sync;
    wire [`ADCIRQ_VALUE_W+`ADCIRQ_CHAN_W-1:0] result_sync;

    adcirq_sync2 #(
        .WIDTH(32)
    ) u_sync_status (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .d_i(live_status_i),
        .q_o(status_sync)
    );

    adcirq_sync2 #(
        .WIDTH(1)
    ) u_sync_toggle (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .d_i(result_toggle_i),
        .q_o(toggle_sync)
    );

    adcirq_sync2 #(
        .WIDTH(`ADCIRQ_VALUE_W+`ADCIRQ_CHAN_W)
    ) u_sync_result (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .d_i({result_channel_i, result_value_i}),
        .q_o(result_sync)
    );

    // ==========================================================
    // State
    reg [31:0] status_prev_reg;
    reg toggle_prev_reg;
    reg [31:0] flags_reg;
    reg [31:0] flags_next;
    reg [31:0] mask_reg;
    reg [31:0] mask_next;
    reg [`ADCIRQ_VALUE_W-1:0] value_reg;
    reg [`ADCIRQ_CHAN_W-1:0] chan_reg;

    wire conv_done;
    wire [31:0] rise;
    wire wr_clear;
    wire wr_en_set;
    wire wr_en_clr;

    assign conv_done = toggle_sync ^ toggle_prev_reg;
    // Overrun and greater-than arrive already qualified by the core, so
    // their edges are taken like any other live status bit.
    assign rise = status_sync & ~status_prev_reg & `ADCIRQ_EDGE_MASK; // R2 R13 R14
    assign wr_clear = wr_i && (addr_i == `ADCIRQ_OFF_FLAG_CLEAR);
    assign wr_en_set = wr_i && (addr_i == `ADCIRQ_OFF_ENABLE_SET);
    assign wr_en_clr = wr_i && (addr_i == `ADCIRQ_OFF_ENABLE_CLEAR);

    // ==========================================================
    // Flags and mask next state
    // Set wins over a clear in the same cycle so no event is lost.
    always @* begin
        flags_next = flags_reg;
        if (wr_clear) begin
            flags_next = flags_next & ~wdata_i; // R4 R5 R6
        end
        flags_next = flags_next | rise; // R2
        if (conv_done) begin
            flags_next[`ADCIRQ_BIT_RESULT_READY] = 1'b1; // R3
        end
        flags_next = flags_next & `ADCIRQ_FLAG_MASK; // R1
    end

    always @* begin
        mask_next = mask_reg;
        if (wr_en_set) begin
            mask_next = mask_next | wdata_i; // R7 R6
        end else if (wr_en_clr) begin
            mask_next = mask_next & ~wdata_i; // R8 R6
        end
        mask_next = mask_next & `ADCIRQ_FLAG_MASK; // R9
    end

    // ==========================================================
    // Registers
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            status_prev_reg <= 32'h0000_0000;
            toggle_prev_reg <= 1'b0;
            flags_reg <= `ADCIRQ_RST_FLAGS;
            mask_reg <= `ADCIRQ_RST_MASK;
            value_reg <= 12'h000;
            chan_reg <= 8'h00;
            irq_o <= 1'b0;
        end else begin
            status_prev_reg <= status_sync;
            toggle_prev_reg <= toggle_sync;
            flags_reg <= flags_next;
            mask_reg <= mask_next;
            if (conv_done) begin
                value_reg <= result_sync[`ADCIRQ_VALUE_W-1:0]; // R10
                chan_reg <= result_sync[`ADCIRQ_VALUE_W+`ADCIRQ_CHAN_W-1:`ADCIRQ_VALUE_W]; // R11
            end
            irq_o <= |(flags_next & mask_next); // R15 R5
        end
    end

    // ==========================================================
    // Read port: unmapped and write-only addresses read zero
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (rd_i) begin
            if (addr_i == `ADCIRQ_OFF_FLAGS) begin
                rdata_o <= flags_reg; // R1
            end else if (addr_i == `ADCIRQ_OFF_MASK_VIEW) begin
                rdata_o <= mask_reg; // R9
            end else if (addr_i == `ADCIRQ_OFF_LAST_RESULT) begin
                rdata_o <= {8'h00, chan_reg, 4'h0, value_reg}; // R10 R11
            end else if (addr_i == `ADCIRQ_OFF_CHAN_PRESENCE) begin
                rdata_o <= CHAN_PRESENCE; // R12
            end else begin
                rdata_o <= 32'h0000_0000;
            end
        end else begin
            rdata_o <= 32'h0000_0000;
        end
    end

endmodule

`default_nettype wire

// >>> sim/adcirq_bank_asserts.sv
// Port checker for the converter interrupt bank.
// Sees only the bank ports; bound below to every bank instance.
`timescale 1ns/10ps
`default_nettype none
module adcirq_bank_asserts #(parameter [31:0] CHAN_PRESENCE = 32'h3ff) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    AST_LAYOUT:
    assert property ($past(rd_i) && $past(addr_i) == 8'h18 |-> !(rdata_o & ~32'h7333))
        else $error("flag layout");
    AST_IDLE:
    assert property (!$past(rd_i) |-> rdata_o == 32'h0) else $error("read data idle");
    AST_WO:
    assert property (rd_i && addr_i inside {8'h1c, 8'h20, 8'h24} |=> rdata_o == 32'h0)
        else $error("write-only read");
    AST_PRES:
    assert property (rd_i && addr_i == 8'h30 |=> rdata_o == CHAN_PRESENCE) else $error("presence");
    AST_FALL:
    assert property ($fell(irq_o) |-> $past(wr_i) && $past(addr_i) inside {8'h1c, 8'h24})
        else $error("irq fell");
    AST_DIS:
    assert property (wr_i && addr_i == 8'h24 && &wdata_i |-> ##[1:2] !irq_o) else $error("irq on");
    AST_OFF:
    assert property (wr_i && addr_i == 8'h24 && &wdata_i ##1 !(wr_i && addr_i == 8'h20) [*3]
        |=> !irq_o) else $error("irq unmasked");
    AST_MASK:
    assert property (wr_i && addr_i == 8'h24 && &wdata_i ##1 !wr_i ##1 rd_i && addr_i == 8'h28
        |=> rdata_o == 32'h0) else $error("mask view");
    cover property (rd_i && addr_i == 8'h2c);
    cover property ($rose(irq_o));
    cover property ($fell(irq_o));
endmodule
bind adcirq_bank adcirq_bank_asserts #(.CHAN_PRESENCE(CHAN_PRESENCE)) i_adcirq_bank_asserts (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));
`default_nettype wire

// >>> sim/adcirq_bank_tb.sv
// Self-checking bench for the converter interrupt bank.
// Drives every port itself; presence set off default to catch a fixed value.
`timescale 1ns/10ps
`default_nettype none
module adcirq_bank_tb;
    localparam logic [31:0] PRES = 32'h8000_02f5;
    logic clk_i = '0, rst_b_i = '0, wr = '0, rd = '0, tg = '0;
    logic [7:0] a = '0, ch = '0;
    logic [11:0] v = '0;
    logic [31:0] wd = '0, lv = '0, fl;
    wire [31:0] rdata;
    wire irq;
    int errors = 0, checks_done = 0, cycles = 0;
    always #12.5 clk_i = ~clk_i;
    adcirq_bank #(.CHAN_PRESENCE(PRES)) i_adcirq_bank (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .addr_i(a), .wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .live_status_i(lv),
        .result_toggle_i(tg), .result_value_i(v), .result_channel_i(ch), .irq_o(irq));
    task automatic check(input logic [31:0] seen, exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Reads compare in the single cycle the data stands
    task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk_i);
        {a, wd, wr, rd} <= {ad, d, w, !w};
        @(posedge clk_i);
        {wr, rd} <= 2'h0;
        @(negedge clk_i);
        if (!w) check(rdata, d, $sformatf("reg %h", ad));
    endtask
    // Six edges cover the two sync stages plus the flag stage
    task automatic hold(input logic [31:0] s);
        @(posedge clk_i);
        lv <= s;
        repeat (6) @(posedge clk_i);
    endtask
    task automatic irq_is(input logic e);
        repeat (2) @(negedge clk_i);
        check({31'h0, irq}, {31'h0, e}, "irq");
    endtask
    task automatic t_reset;
        logic [7:0] m [8] = '{8'h18, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h34};
        foreach (m[i]) bus(0, m[i], m[i] == 8'h30 ? PRES : 32'h0);
        $display("reset values done");
    endtask
    task automatic t_edges;
        int b [8] = '{14, 13, 12, 9, 8, 5, 4, 1};
        fl = 32'h0;
        bus(1, 8'h20, 32'hffff_ffff);
        bus(0, 8'h28, 32'h7333);
        hold(32'hffff_8ccd);
        bus(0, 8'h18, 32'h0);
        foreach (b[i]) begin
            fl[b[i]] = 1'h1;
            hold(lv | fl);
            bus(0, 8'h18, fl);
        end
        irq_is(1);
        hold(32'h0);
        bus(0, 8'h18, fl);
        $display("status edges done");
    endtask
    task automatic t_clear;
        bus(1, 8'h1c, 32'h0);
        bus(0, 8'h18, 32'h7332);
        bus(1, 8'h1c, 32'h2000);
        bus(0, 8'h18, 32'h5332);
        bus(1, 8'h1c, 32'hffff_ffff);
        irq_is(0);
        bus(0, 8'h18, 32'h0);
        $display("flag clear done");
    endtask
    task automatic t_mask;
        bus(1, 8'h24, 32'h4000);
        bus(0, 8'h28, 32'h3333);
        bus(1, 8'h20, 32'h0);
        bus(1, 8'h24, 32'h0);
        bus(0, 8'h28, 32'h3333);
        hold(32'h4000);
        irq_is(0);
        bus(1, 8'h20, 32'h4000);
        irq_is(1);
        bus(1, 8'h24, 32'hffff_ffff);
        bus(0, 8'h28, 32'h0);
        irq_is(0);
        $display("mask done");
    endtask
    task automatic t_result;
        logic [31:0] r [2] = '{32'h0009_0a5c, 32'h00ff_0fff};
        foreach (r[i]) begin
            @(posedge clk_i);
            {ch, v} <= {r[i][23:16], r[i][11:0]};
            @(posedge clk_i);
            tg <= ~tg;
            hold(lv);
            bus(0, 8'h2c, r[i]);
            bus(0, 8'h18, 32'h4001);
            bus(1, 8'h1c, 32'h1);
        end
        @(posedge clk_i);
        {ch, v} <= 20'h45123;
        hold(lv);
        bus(0, 8'h2c, r[1]);
        $display("result done");
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk_i);
        rst_b_i <= 1'h1;
        t_reset();
        t_edges();
        t_clear();
        t_mask();
        t_result();
        report_and_stop();
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            report_and_stop();
        end
    end
endmodule
`default_nettype wire
